/* File: gpc_params.svh */
`ifndef GPC_PARAMS_SVH
`define GPC_PARAMS_SVH
`define GPC_CTRL_OFFSET   12'h0FC
`define GPC_CTRL_RESET    32'h00001010
`define GPC_CTRL_WMASK    32'h3131B1B1
`define GPC_DATA0_BIT     0
`define GPC_OE0_BIT       4
`define GPC_INV0_BIT      5
`define GPC_CON_DIS_BIT   7
`define GPC_DATA1_BIT     8
`define GPC_OE1_BIT       12
`define GPC_INV1_BIT      13
`define GPC_PWR_DIS_BIT   15
`define GPC_DATA2_BIT     16
`define GPC_OE2_BIT       20
`define GPC_INV2_BIT      21
`define GPC_DATA3_BIT     24
`define GPC_OE3_BIT       28
`define GPC_INV3_BIT      29
`endif

/* File: gpc_pkg.sv */
package gpc_pkg;
	typedef logic [3:0] gpc_nib_t;
	typedef enum logic [1:0] {GPC_IDLE, GPC_ACCESS} gpc_state_t;
endpackage

/* File: gpc_term_if.sv */
`timescale 1ns/1ps
interface gpc_term_if;
	logic [3:0] inv;
	logic [3:0] oe;
	logic [3:0] dout;
	logic [3:0] pad_in;
	logic [3:0] pad_out;
	logic [3:0] pad_oe;
	logic [3:0] level;
	modport ctrl (output inv, output oe, output dout, input level);
	modport pads (input inv, input oe, input dout, output level,
		input pad_in, output pad_out, output pad_oe);
	modport top  (output pad_in, input pad_out, input pad_oe);
endinterface

/* File: gpc_sync.sv */
`timescale 1ns/1ps
module gpc_sync
	import gpc_pkg::*;
#(
	parameter int WIDTH = 4
)
(
	// Clock and reset
	input  wire logic             pclk,
	input  wire logic             presetn,
	// Data
	input  wire logic [WIDTH-1:0] async_in,
	output logic      [WIDTH-1:0] sync_out
);
	logic [WIDTH-1:0] meta_reg;
	logic [WIDTH-1:0] sync_reg;

	// First stage feeds only the second
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			meta_reg <= '0;
			sync_reg <= '0;
		end
		else
		begin
			meta_reg <= async_in;
			sync_reg <= meta_reg;
		end
	end

	assign sync_out = sync_reg;
endmodule

/* File: gpc_pads.sv */
`timescale 1ns/1ps
module gpc_pads
	import gpc_pkg::*;
(
	// Terminals, pad_in already synchronised
	gpc_term_if.pads term
);
	// Polarity applies both ways, so software sees logical values
	assign term.pad_out = term.dout ^ term.inv;
	assign term.pad_oe  = term.oe;
	assign term.level   = term.pad_in ^ term.inv;
endmodule

/* File: gpc_general_io.sv */
`timescale 1ns/1ps
`include "gpc_params.svh"
module gpc_general_io
	import gpc_pkg::*;
(
	// APB clock and reset
	input  wire logic        pclk,
	input  wire logic        presetn,
	// APB slave
	input  wire logic        psel,
	input  wire logic        penable,
	input  wire logic        pwrite,
	input  wire logic [11:0] paddr,
	input  wire logic [31:0] pwdata,
	input  wire logic [3:0]  pstrb,
	output logic      [31:0] prdata,
	output logic             pready,
	output logic             pslverr,
	// Dedicated link signals from the link core
	input  wire logic        bus_manager_contender,
	input  wire logic        link_power_status,
	// Terminals
	input  wire logic [3:0]  gp_terminal_in,
	output logic      [3:0]  gp_terminal_out,
	output logic      [3:0]  gp_terminal_oe
);
	logic [31:0] general_io_control_reg;
	logic [31:0] general_io_control_next;
	logic [31:0] prdata_reg;
	logic [31:0] prdata_next;
	logic        pslverr_reg;
	logic        pslverr_next;
	gpc_state_t  state_reg;
	gpc_state_t  state_next;
	logic [3:0]  pad_sync;

	gpc_term_if term();

	// Pads are asynchronous to pclk; nothing reads them before the second flop
	gpc_sync #(.WIDTH(4)) u_sync
	(
		.pclk     (pclk),
		.presetn  (presetn),
		.async_in (gp_terminal_in),
		.sync_out (pad_sync)
	);

	gpc_pads u_pads
	(
		.term (term.pads)
	);

	assign term.pad_in      = pad_sync;
	assign gp_terminal_out  = term.pad_out;
	assign gp_terminal_oe   = term.pad_oe;

	function automatic logic [31:0] strb_merge(input logic [31:0] old_v,
		input logic [31:0] new_v, input logic [3:0] strb);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}} & `GPC_CTRL_WMASK;
		return (old_v & ~m) | (new_v & m);
	endfunction

	// Decode
	wire ctrl_hit   = (paddr == `GPC_CTRL_OFFSET);
	wire setup_ph   = psel && !penable;
	wire access_ph  = psel && penable;
	wire wr_commit  = access_ph && pwrite && ctrl_hit;

	// Mode selection
	wire gp0_mode = general_io_control_reg[`GPC_CON_DIS_BIT];
	wire gp1_mode = general_io_control_reg[`GPC_PWR_DIS_BIT];

	wire [3:0] f_inv = {general_io_control_reg[`GPC_INV3_BIT],
		general_io_control_reg[`GPC_INV2_BIT],
		general_io_control_reg[`GPC_INV1_BIT],
		general_io_control_reg[`GPC_INV0_BIT]};
	wire [3:0] f_oe = {general_io_control_reg[`GPC_OE3_BIT],
		general_io_control_reg[`GPC_OE2_BIT],
		general_io_control_reg[`GPC_OE1_BIT],
		general_io_control_reg[`GPC_OE0_BIT]};
	wire [3:0] f_dat = {general_io_control_reg[`GPC_DATA3_BIT],
		general_io_control_reg[`GPC_DATA2_BIT],
		general_io_control_reg[`GPC_DATA1_BIT],
		general_io_control_reg[`GPC_DATA0_BIT]};

	// Dedicated signals always drive and pass uninverted
	assign term.inv[3]  = f_inv[3];
	assign term.inv[2]  = f_inv[2];
	assign term.inv[1]  = gp1_mode & f_inv[1];
	assign term.inv[0]  = gp0_mode & f_inv[0];
	assign term.oe[3]   = f_oe[3];
	assign term.oe[2]   = f_oe[2];
	assign term.oe[1]   = gp1_mode ? f_oe[1] : 1'b1;
	assign term.oe[0]   = gp0_mode ? f_oe[0] : 1'b1;
	assign term.dout[3] = f_dat[3];
	assign term.dout[2] = f_dat[2];
	assign term.dout[1] = gp1_mode ? f_dat[1] : link_power_status;
	assign term.dout[0] = gp0_mode ? f_dat[0] : bus_manager_contender;

	// Data bits read the terminal, so an input-only pin can be sampled
	wire [31:0] read_view = (general_io_control_reg & `GPC_CTRL_WMASK)
		& ~(32'h01010101)
		| {7'h00, term.level[3], 7'h00, term.level[2],
		   7'h00, term.level[1], 7'h00, term.level[0]};

	always_comb
	begin
		general_io_control_next = general_io_control_reg;
		if (wr_commit)
			general_io_control_next = strb_merge(general_io_control_reg, pwdata, pstrb);
	end

	always_comb
	begin
		state_next   = state_reg;
		prdata_next  = prdata_reg;
		pslverr_next = 1'b0;
		case (state_reg)
			GPC_IDLE:
			begin
				if (setup_ph)
				begin
					state_next   = GPC_ACCESS;
					prdata_next  = (!pwrite && ctrl_hit) ? read_view : 32'h00000000;
					pslverr_next = !ctrl_hit;
				end
			end
			GPC_ACCESS:
			begin
				state_next = GPC_IDLE;
			end
			default:
			begin
				state_next = GPC_IDLE;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			general_io_control_reg <= `GPC_CTRL_RESET;
			prdata_reg             <= 32'h00000000;
			pslverr_reg            <= 1'b0;
			state_reg              <= GPC_IDLE;
		end
		else
		begin
			general_io_control_reg <= general_io_control_next;
			prdata_reg             <= prdata_next;
			pslverr_reg            <= pslverr_next;
			state_reg              <= state_next;
		end
	end

	// Zero-wait slave: every access phase completes at once
	assign pready  = 1'b1;
	assign prdata  = prdata_reg;
	assign pslverr = pslverr_reg;

	property p_reserved_zero;
		@(posedge pclk) disable iff (!presetn)
		(general_io_control_reg & ~`GPC_CTRL_WMASK) == 32'h00000000;
	endproperty
	a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bits set");

	property p_t0_dedicated;
		@(posedge pclk) disable iff (!presetn)
		!gp0_mode |-> gp_terminal_oe[0] && gp_terminal_out[0] == bus_manager_contender;
	endproperty
	a_t0_dedicated: assert property (p_t0_dedicated) else $error("t0 not contender");

	property p_t1_dedicated;
		@(posedge pclk) disable iff (!presetn)
		!gp1_mode |-> gp_terminal_oe[1] && gp_terminal_out[1] == link_power_status;
	endproperty
	a_t1_dedicated: assert property (p_t1_dedicated) else $error("t1 not power status");

	property p_t3_drive;
		@(posedge pclk) disable iff (!presetn)
		gp_terminal_oe[3] == f_oe[3] && gp_terminal_out[3] == (f_dat[3] ^ f_inv[3]);
	endproperty
	a_t3_drive: assert property (p_t3_drive) else $error("t3 drive wrong");

	property p_t2_drive;
		@(posedge pclk) disable iff (!presetn)
		gp_terminal_oe[2] == f_oe[2] && gp_terminal_out[2] == (f_dat[2] ^ f_inv[2]);
	endproperty
	a_t2_drive: assert property (p_t2_drive) else $error("t2 drive wrong");

	property p_t0_gp;
		@(posedge pclk) disable iff (!presetn)
		gp0_mode |-> gp_terminal_oe[0] == f_oe[0]
			&& gp_terminal_out[0] == (f_dat[0] ^ f_inv[0]);
	endproperty
	a_t0_gp: assert property (p_t0_gp) else $error("t0 general drive wrong");

	property p_t1_gp;
		@(posedge pclk) disable iff (!presetn)
		gp1_mode |-> gp_terminal_oe[1] == f_oe[1]
			&& gp_terminal_out[1] == (f_dat[1] ^ f_inv[1]);
	endproperty
	a_t1_gp: assert property (p_t1_gp) else $error("t1 general drive wrong");

	property p_write_lands;
		@(posedge pclk) disable iff (!presetn)
		wr_commit && pstrb == 4'hF |=> general_io_control_reg == ($past(pwdata) & `GPC_CTRL_WMASK);
	endproperty
	a_write_lands: assert property (p_write_lands) else $error("write not stored");

	property p_read_level;
		@(posedge pclk) disable iff (!presetn)
		setup_ph && !pwrite && ctrl_hit && state_reg == GPC_IDLE
			|=> prdata[`GPC_DATA3_BIT] == $past(term.level[3]);
	endproperty
	a_read_level: assert property (p_read_level) else $error("read level wrong");

	property p_read_level0;
		@(posedge pclk) disable iff (!presetn)
		setup_ph && !pwrite && ctrl_hit && state_reg == GPC_IDLE
			|=> prdata[`GPC_DATA0_BIT] == $past(term.level[0]);
	endproperty
	a_read_level0: assert property (p_read_level0) else $error("read level 0 wrong");

	property p_read_level1;
		@(posedge pclk) disable iff (!presetn)
		setup_ph && !pwrite && ctrl_hit && state_reg == GPC_IDLE
			|=> prdata[`GPC_DATA1_BIT] == $past(term.level[1]);
	endproperty
	a_read_level1: assert property (p_read_level1) else $error("read level 1 wrong");

	property p_read_level2;
		@(posedge pclk) disable iff (!presetn)
		setup_ph && !pwrite && ctrl_hit && state_reg == GPC_IDLE
			|=> prdata[`GPC_DATA2_BIT] == $past(term.level[2]);
	endproperty
	a_read_level2: assert property (p_read_level2) else $error("read level 2 wrong");

	property p_t3_hiz;
		@(posedge pclk) disable iff (!presetn)
		!f_oe[3] |-> !gp_terminal_oe[3];
	endproperty
	a_t3_hiz: assert property (p_t3_hiz) else $error("t3 driven while disabled");

	property p_t2_hiz;
		@(posedge pclk) disable iff (!presetn)
		!f_oe[2] |-> !gp_terminal_oe[2];
	endproperty
	a_t2_hiz: assert property (p_t2_hiz) else $error("t2 driven while disabled");

	property p_t3_data;
		@(posedge pclk) disable iff (!presetn)
		f_oe[3] && !f_inv[3] |-> gp_terminal_out[3] == f_dat[3];
	endproperty
	a_t3_data: assert property (p_t3_data) else $error("t3 data wrong");

	property p_t2_data;
		@(posedge pclk) disable iff (!presetn)
		f_oe[2] && !f_inv[2] |-> gp_terminal_out[2] == f_dat[2];
	endproperty
	a_t2_data: assert property (p_t2_data) else $error("t2 data wrong");

	property p_t3_in_pol;
		@(posedge pclk) disable iff (!presetn)
		term.level[3] == (term.pad_in[3] ^ f_inv[3]);
	endproperty
	a_t3_in_pol: assert property (p_t3_in_pol) else $error("t3 input polarity wrong");

	property p_t2_in_pol;
		@(posedge pclk) disable iff (!presetn)
		term.level[2] == (term.pad_in[2] ^ f_inv[2]);
	endproperty
	a_t2_in_pol: assert property (p_t2_in_pol) else $error("t2 input polarity wrong");

	property p_t1_inv;
		@(posedge pclk) disable iff (!presetn)
		gp1_mode && f_inv[1]
			|-> gp_terminal_out[1] != f_dat[1] && term.level[1] != term.pad_in[1];
	endproperty
	a_t1_inv: assert property (p_t1_inv) else $error("t1 polarity wrong");

	property p_t1_oe;
		@(posedge pclk) disable iff (!presetn)
		gp1_mode |-> gp_terminal_oe[1] == f_oe[1];
	endproperty
	a_t1_oe: assert property (p_t1_oe) else $error("t1 enable wrong");

	property p_t1_data;
		@(posedge pclk) disable iff (!presetn)
		gp1_mode && f_oe[1] && !f_inv[1]
			|-> gp_terminal_out[1] == f_dat[1];
	endproperty
	a_t1_data: assert property (p_t1_data) else $error("t1 data wrong");

	property p_t0_inv;
		@(posedge pclk) disable iff (!presetn)
		gp0_mode && f_inv[0]
			|-> gp_terminal_out[0] != f_dat[0] && term.level[0] != term.pad_in[0];
	endproperty
	a_t0_inv: assert property (p_t0_inv) else $error("t0 polarity wrong");

	property p_t0_oe;
		@(posedge pclk) disable iff (!presetn)
		gp0_mode |-> gp_terminal_oe[0] == f_oe[0];
	endproperty
	a_t0_oe: assert property (p_t0_oe) else $error("t0 enable wrong");

	property p_t0_data;
		@(posedge pclk) disable iff (!presetn)
		gp0_mode && f_oe[0] && !f_inv[0]
			|-> gp_terminal_out[0] == f_dat[0];
	endproperty
	a_t0_data: assert property (p_t0_data) else $error("t0 data wrong");

	property p_read_reserved;
		@(posedge pclk) disable iff (!presetn)
		setup_ph && state_reg == GPC_IDLE
			|=> (prdata & ~`GPC_CTRL_WMASK) == 32'h00000000;
	endproperty
	a_read_reserved: assert property (p_read_reserved) else $error("reserved bits read");

	property p_hold_fields;
		@(posedge pclk) disable iff (!presetn)
		!wr_commit |=> $stable(general_io_control_reg);
	endproperty
	a_hold_fields: assert property (p_hold_fields) else $error("fields changed");

	property p_dedicated_in;
		@(posedge pclk) disable iff (!presetn)
		!gp0_mode |-> term.level[0] == term.pad_in[0];
	endproperty
	a_dedicated_in: assert property (p_dedicated_in) else $error("t0 input inverted");

	property p_unmapped_err;
		@(posedge pclk) disable iff (!presetn)
		setup_ph && !ctrl_hit && state_reg == GPC_IDLE
			|=> pslverr && prdata == 32'h00000000;
	endproperty
	a_unmapped_err: assert property (p_unmapped_err) else $error("bad unmapped access");
endmodule

/* File: gpc_board_model.sv */
`timescale 1ns/1ps
module gpc_board_model
	import gpc_pkg::*;
(
	// Design side
	input  wire logic [3:0] drv_out,
	input  wire logic [3:0] drv_oe,
	// Board side
	input  wire logic [3:0] ext_level,
	output logic      [3:0] pad_level
);
	// No pull-ups fitted: an undriven pad shows what the board circuit forces on it
	assign pad_level = (drv_oe & drv_out) | (~drv_oe & ext_level);
endmodule

/* File: tb.sv */
`timescale 1ns/1ps
module tb;
	import gpc_pkg::*;
	logic        pclk;
	logic        presetn;
	logic        psel;
	logic        penable;
	logic        pwrite;
	logic [11:0] paddr;
	logic [31:0] pwdata;
	logic [31:0] prdata;
	logic        pready;
	logic        pslverr;
	logic        contender;
	logic        power_stat;
	logic [3:0]  pstrb;
	logic [3:0]  strb;
	logic [3:0]  ext;
	logic [3:0]  pad;
	logic [3:0]  t_out;
	logic [3:0]  t_oe;
	logic [31:0] r;
	logic        e;
	int          error_cnt;
	int          samples_checked;
	// Write value, {contender, power status, board level}, {oe, out}, readback
	logic [31:0] tw [4] = '{32'h3131B1B1, 32'h11119191, 32'h20208080, 32'h00002121};
	logic [5:0]  tin [4] = '{6'h00, 6'h00, 6'h05, 6'h1F};
	logic [7:0]  tpin [4] = '{8'hF0, 8'hFF, 8'h0C, 8'h32};
	logic [31:0] trd [4] = '{32'h3131B1B1, 32'h11119191, 32'h21208081, 32'h01012120};

	gpc_general_io i_gpc_general_io (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.bus_manager_contender(contender), .link_power_status(power_stat),
		.gp_terminal_in(pad), .gp_terminal_out(t_out), .gp_terminal_oe(t_oe));
	gpc_board_model i_gpc_board_model (.drv_out(t_out), .drv_oe(t_oe),
		.ext_level(ext), .pad_level(pad));

	always #12.5 pclk = ~pclk;

	task end_of_test;
		$display("checks %0d mismatches %0d", samples_checked, error_cnt);
		if (error_cnt == 0 && samples_checked > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	task chk(input logic [31:0] g, input logic [31:0] x, input string m);
		samples_checked++;
		if (g !== x)
		begin
			error_cnt++;
			$display("mismatch at %0t: %s got %h exp %h", $time, m, g, x);
		end
	endtask

	// Waits for pready however long the slave takes; only the watchdog ends a hang
	task apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
		@(posedge pclk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= a;
		pwdata  <= d;
		pstrb   <= strb;
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		r = prdata;
		e = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	initial
	begin
		#(3000 * 25);
		error_cnt++;
		$display("mismatch at %0t: timeout", $time);
		end_of_test;
	end

	initial
	begin
		pclk = 0;
		presetn = 0;
		psel = 0;
		penable = 0;
		pwrite = 0;
		paddr = 12'h000;
		pwdata = 32'h0;
		pstrb = 4'hF;
		strb = 4'hF;
		contender = 1;
		power_stat = 0;
		ext = 4'h0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		repeat (4) @(posedge pclk);
		chk({24'h0, t_oe, t_out}, 32'h00000031, "reset pins");
		apb(1'b0, 12'h0FC, 32'h0);
		chk(r, 32'h00001011, "reset read");
		for (int i = 0; i < 4; i++)
		begin
			{contender, power_stat, ext} <= tin[i];
			apb(1'b1, 12'h0FC, tw[i]);
			// Two sync flops plus capture before readback sees the pads
			repeat (4) @(posedge pclk);
			chk({24'h0, t_oe, t_out}, {24'h0, tpin[i]}, "pins");
			apb(1'b0, 12'h0FC, 32'h0);
			chk(r, trd[i], "readback");
			$display("test %0d done", i);
		end
		apb(1'b1, 12'h0F8, 32'hFFFFFFFF);
		chk({31'h0, e}, 32'h1, "unmapped write error");
		apb(1'b0, 12'h0F8, 32'h0);
		chk({31'h0, e}, 32'h1, "unmapped read error");
		chk(r, 32'h0, "unmapped data");
		apb(1'b0, 12'h0FC, 32'h0);
		chk(r, trd[3], "unmapped no effect");
		$display("test unmapped done");
		// Only byte lane 0 may land: terminal 0 goes general, terminal 1 stays dedicated
		strb = 4'h1;
		apb(1'b1, 12'h0FC, 32'hFFFFFFB0);
		strb = 4'hF;
		repeat (4) @(posedge pclk);
		chk({24'h0, t_oe, t_out}, 32'h00000033, "strobe pins");
		apb(1'b0, 12'h0FC, 32'h0);
		chk(r, 32'h010121B0, "strobe readback");
		$display("test strobe done");
		end_of_test;
	end
endmodule
